// ==== include/bkc_pkg.sv ====
// constants, types and carrier structs for the buck control sequencer
// ==========================================================
package bkc_pkg;

    // ==========================================================
    // timing counts, in oscillator periods except OSC_DIV, in ref clocks, and BURST_PERIODS, in switching periods
    localparam int SS_PERIODS    = 2048;  // soft start length
    localparam int PG_DEGLITCH   = 32;    // output-ok persistence
    localparam int BURST_PERIODS = 4;     // periods per skip burst
    localparam int OSC_DIV       = 128;   // ref clocks per oscillator period
    localparam int SS_W          = $clog2(SS_PERIODS);
    localparam int PG_W          = $clog2(PG_DEGLITCH);

    // ==========================================================
    // register map, byte addresses on the wishbone port
    localparam logic [7:0] ADDR_CTRL   = 8'h00;
    localparam logic [7:0] ADDR_STATUS = 8'h04;
    localparam logic [7:0] ADDR_RAMP   = 8'h08;
    localparam int         CTRL_SW_EN  = 0;     // software enable bit
    localparam int         CTRL_NOSKIP = 1;     // force pwm, no skipping
    localparam int         CTRL_W      = 2;
    localparam logic [1:0] CTRL_RESET  = 2'h1;  // enabled, skipping allowed

    // ==========================================================
    // comparator inputs from the analog side, all asynchronous
    typedef struct packed {
        logic en_above_hi;     // turn-on pin above upper threshold
        logic en_below_lo;     // turn-on pin below lower threshold
        logic vin_below_fall;  // input below lockout level
        logic vin_above_rise;  // input above release level
        logic temp_hot;        // junction above cutoff
        logic temp_cool;       // junction below recovery level
        logic fb_ov_hi;        // feedback above guard level
        logic fb_ov_lo;        // feedback below guard release
        logic fb_ok_hi;        // feedback above upper ok fraction
        logic fb_ok_lo;        // feedback below lower ok fraction
        logic fb_ge_top;       // feedback at or above top band edge
        logic fb_gt_mid;       // feedback above middle band edge
        logic fb_gt_bot;       // feedback above bottom band edge
        logic peak_trip;       // inductor current at peak threshold
        logic cur_limit;       // positive switch current limit
        logic skip_in_reg;     // skip comparator: output in regulation
    } bkc_cmp_s;
    localparam int CMP_W = $bits(bkc_cmp_s);

    // foldback bands, fastest first
    typedef enum logic [1:0] {
        BAND_FULL,
        BAND_HALF,
        BAND_QUARTER,
        BAND_EIGHTH
    } bkc_band_e;

    // ==========================================================
    // whole state of the sequencer
    typedef struct packed {
        logic                 en_pin;     // hysteretic enable latch
        logic                 lockout;    // input low lockout
        logic                 cutoff;     // thermal cutoff
        logic                 guard;      // output high guard
        logic                 short_seen; // lowest band was entered
        logic [7:0]           osc_cnt;    // oscillator divider
        logic [2:0]           pre_cnt;    // foldback prescaler
        bkc_band_e            band;       // current foldback band
        logic [SS_W-1:0]      ss_cnt;     // soft start ramp
        logic                 ss_done;    // ramp complete
        logic [2:0]           burst;      // skip burst periods left
        logic                 sw_on;      // switch gate request
        logic                 sw_clk;     // divided switching clock pulse
        logic                 ok;         // output-ok released
        logic [PG_W-1:0]      ok_cnt;     // deglitch counter
        logic [CTRL_W-1:0]    ctrl;       // software control bits
        logic                 ack;        // wishbone acknowledge
        logic [31:0]          dat;        // wishbone read data
    } bkc_state_s;

endpackage

// ==== verilog/bkc_sync.sv ====
// two-flop synchroniser bank for asynchronous comparator levels
`timescale 1ns/1ns

module bkc_sync #(
    parameter int W = 1  // number of independent levels
) (
    input  wire logic         clk,
    input  wire logic         rst_n,
    input  wire logic [W-1:0] d,
    output logic      [W-1:0] q
);

    // ==========================================================
    // one pair of flops per bit; the first flop feeds only the second
    genvar i;
    generate
        for (i = 0; i < W; i++) begin : g_bit
            logic meta_q;  // metastability catcher

            // resets low; comparators settle during reset
            always_ff @(posedge clk or negedge rst_n) begin
                if (!rst_n) begin
                    meta_q <= 1'b0;
                    q[i]   <= 1'b0;
                end else begin
                    meta_q <= d[i];
                    q[i]   <= meta_q;
                end
            end
        end
    endgenerate

endmodule

// ==== verilog/bkc_seq.sv ====
// control and sequencing logic of a nonsynchronous step-down regulator
`timescale 1ns/1ns

module bkc_seq
    import bkc_pkg::*;
#(
    parameter int OSC_DIVIDE = OSC_DIV,       // ref clocks per oscillator period
    parameter int SS_LEN     = SS_PERIODS,    // soft start periods
    parameter int BURST_LEN  = BURST_PERIODS  // periods in a skip burst
) (
    input  wire logic        REF_CLK,
    input  wire logic        RST_N,
    input  wire logic        WB_CYC_I,
    input  wire logic        WB_STB_I,
    input  wire logic        WB_WE_I,
    input  wire logic [7:0]  WB_ADR_I,
    input  wire logic [3:0]  WB_SEL_I,
    input  wire logic [31:0] WB_DAT_I,
    output logic      [31:0] WB_DAT_O,
    output logic             WB_ACK_O,
    input  wire bkc_cmp_s    CMP_I,
    output logic             SW_ON,
    output logic             SW_CLK,
    output logic [SS_W-1:0]  SOFT_START_LEVEL,
    output logic             OUTPUT_OK_O,
    output logic             OUTPUT_OK_OE
);

    // ==========================================================
    // comparator synchronisation
    logic [CMP_W-1:0] cmp_raw;   // flattened comparator levels
    logic [CMP_W-1:0] cmp_sync;  // after two flops
    bkc_cmp_s         c;         // synchronised view

    assign cmp_raw = CMP_I;

    bkc_sync #(
        .W (CMP_W)
    ) u_sync (
        .clk   (REF_CLK),
        .rst_n (RST_N),
        .d     (cmp_raw),
        .q     (cmp_sync)
    );

    assign c = bkc_cmp_s'(cmp_sync);

    // ==========================================================
    // state registers
    bkc_state_s s_q;  // registered state
    bkc_state_s s_d;  // next state

    // derived terms, combinational
    logic       osc_tick;    // first ref clock of an oscillator period
    logic       per_start;   // start of a switching period
    logic       run;         // all enable conditions met
    logic       leave_short; // feedback leaving the lowest band
    logic       restart;     // soft start must begin again
    logic       want_on;     // switching demanded this period
    logic       trip;        // peak trip or current limit on-pulse terminator
    logic       ok_change;   // deglitch condition present
    logic [2:0] band_mask;   // prescaler bits that must be zero
    bkc_band_e  band_now;    // band from present comparator levels
    logic       req;         // new wishbone request
    logic [31:0] rd_data;    // read multiplexer

    // ==========================================================
    // band decode from feedback comparators
    always_comb begin
        if (c.fb_ge_top) begin
            band_now = BAND_FULL;
        end else if (c.fb_gt_mid) begin
            band_now = BAND_HALF;
        end else if (c.fb_gt_bot) begin
            band_now = BAND_QUARTER;
        end else begin
            band_now = BAND_EIGHTH;
        end
    end

    // prescaler mask per band; period starts when masked bits are zero
    always_comb begin
        unique case (s_q.band)
            BAND_FULL:    band_mask = 3'h0;
            BAND_HALF:    band_mask = 3'h1;
            BAND_QUARTER: band_mask = 3'h3;
            BAND_EIGHTH:  band_mask = 3'h7;
        endcase
    end

    // ==========================================================
    // shared terms
    always_comb begin
        osc_tick    = (s_q.osc_cnt == 8'h00);
        per_start   = osc_tick && ((s_q.pre_cnt & band_mask) == 3'h0);
        // the flag bit lets software hold the regulator off as well
        run         = s_q.en_pin && !s_q.lockout && !s_q.cutoff
                      && s_q.ctrl[CTRL_SW_EN];
        leave_short = s_q.short_seen && (band_now != BAND_EIGHTH);
        restart     = !run || leave_short;
        // forced pwm or out of regulation or burst still running
        want_on     = s_q.ctrl[CTRL_NOSKIP] || !c.skip_in_reg
                      || (s_q.burst != 3'h0);
        trip        = c.peak_trip || c.cur_limit;
        // counts only while the level disagrees with the flag
        ok_change   = s_q.ok ? c.fb_ok_lo : c.fb_ok_hi;
        req         = WB_CYC_I && WB_STB_I && !s_q.ack;
    end

    // read multiplexer; unmapped addresses read zero
    always_comb begin
        rd_data = 32'h0;
        unique case (WB_ADR_I)
            ADDR_CTRL:   rd_data[CTRL_W-1:0] = s_q.ctrl;
            ADDR_STATUS: rd_data[9:0] = {s_q.band, s_q.ss_done, s_q.ok,
                                          s_q.sw_on, s_q.guard, s_q.cutoff,
                                          s_q.lockout, s_q.en_pin, run};
            ADDR_RAMP:   rd_data[SS_W-1:0] = s_q.ss_cnt;
            default:     rd_data = 32'h0;
        endcase
    end

    // ==========================================================
    // next state
    always_comb begin
        s_d = s_q;

        // oscillator: free running divider of the reference clock
        if (s_q.osc_cnt == 8'(OSC_DIVIDE - 1)) begin
            s_d.osc_cnt = 8'h00;
        end else begin
            s_d.osc_cnt = s_q.osc_cnt + 8'h01;
        end
        if (osc_tick) begin
            s_d.pre_cnt = s_q.pre_cnt + 3'h1;
        end

        // band changes only on a period edge, so no short periods appear
        if (per_start) begin
            s_d.band = band_now;
        end

        // enable pin hysteresis: set above upper, clear below lower
        if (c.en_above_hi) begin
            s_d.en_pin = 1'b1;
        end else if (c.en_below_lo) begin
            s_d.en_pin = 1'b0;
        end

        // input lockout with its own hysteresis
        if (c.vin_below_fall) begin
            s_d.lockout = 1'b1;
        end else if (c.vin_above_rise) begin
            s_d.lockout = 1'b0;
        end

        // thermal cutoff holds until the cool indication
        if (c.temp_hot) begin
            s_d.cutoff = 1'b1;
        end else if (c.temp_cool) begin
            s_d.cutoff = 1'b0;
        end

        // overvoltage guard between its two levels
        if (c.fb_ov_hi) begin
            s_d.guard = 1'b1;
        end else if (c.fb_ov_lo) begin
            s_d.guard = 1'b0;
        end

        // hard short tracking; cleared on leaving the lowest band, which restarts the ramp
        if (band_now == BAND_EIGHTH) begin
            s_d.short_seen = 1'b1;
        end else if (leave_short) begin
            s_d.short_seen = 1'b0;
        end

        // soft start ramp, one step per oscillator period
        if (restart) begin
            s_d.ss_cnt  = '0;
            s_d.ss_done = 1'b0;
        end else if (osc_tick && !s_q.ss_done) begin
            if (s_q.ss_cnt == SS_W'(SS_LEN - 1)) begin
                s_d.ss_done = 1'b1;
            end else begin
                s_d.ss_cnt = s_q.ss_cnt + 1'b1;
            end
        end

        // divided switching clock, one ref cycle per period
        s_d.sw_clk = per_start;

        // skip burst: reload while out of regulation, count down per period
        if (!run) begin
            s_d.burst = 3'h0;
        end else if (per_start) begin
            if (!c.skip_in_reg) begin
                s_d.burst = 3'(BURST_LEN - 1);
            end else if (s_q.burst != 3'h0) begin
                s_d.burst = s_q.burst - 3'h1;
            end
        end

        // switch gate: set only at period start, cleared by any terminator
        if (!run || s_q.guard || trip) begin
            s_d.sw_on = 1'b0;
        end else if (per_start) begin
            s_d.sw_on = want_on;
        end

        // output-ok flag with deglitch in oscillator periods
        if (!run) begin
            s_d.ok     = 1'b0;
            s_d.ok_cnt = '0;
        end else if (!ok_change) begin
            s_d.ok_cnt = '0;
        end else if (osc_tick) begin
            if (s_q.ok_cnt == PG_W'(PG_DEGLITCH - 1)) begin
                s_d.ok     = !s_q.ok;
                s_d.ok_cnt = '0;
            end else begin
                s_d.ok_cnt = s_q.ok_cnt + 1'b1;
            end
        end

        // wishbone slave: ack one cycle after the request, then drop;
        // a write lands only at the edge where the master sees ack high
        s_d.ack = req;
        s_d.dat = req ? rd_data : 32'h0;
        if (WB_CYC_I && WB_STB_I && s_q.ack && WB_WE_I && (WB_ADR_I == ADDR_CTRL) && WB_SEL_I[0]) begin
            s_d.ctrl = WB_DAT_I[CTRL_W-1:0];
        end
    end

    // ==========================================================
    // state register; a reset starts in lockout with everything off except the software enable bit
    always_ff @(posedge REF_CLK or negedge RST_N) begin
        if (!RST_N) begin
            s_q            <= '0;
            s_q.lockout    <= 1'b1;
            s_q.band       <= BAND_FULL;
            s_q.ctrl       <= CTRL_RESET;
        end else begin
            s_q <= s_d;
        end
    end

    // ==========================================================
    // outputs straight from the state register, except the output-ok level, a constant low, and its enable, the inverted ok flag
    assign SW_ON            = s_q.sw_on;
    assign SW_CLK           = s_q.sw_clk;
    assign SOFT_START_LEVEL = s_q.ss_cnt;
    assign WB_ACK_O         = s_q.ack;
    assign WB_DAT_O         = s_q.dat;
    // open drain: only ever pulls low, enable high while pulling
    assign OUTPUT_OK_O      = 1'b0;
    assign OUTPUT_OK_OE     = !s_q.ok;

endmodule

// ==== verif/bkc_seq_properties.sv ====
// concurrent checks on the top-level ports of the buck control sequencer
`timescale 1ns/1ns

module bkc_seq_properties
    import bkc_pkg::*;
#(
    parameter int OSC_DIVIDE = OSC_DIV  // ref clocks per oscillator period
) (
    input wire logic            REF_CLK,
    input wire logic            RST_N,
    input wire logic            WB_ACK_O,
    input wire bkc_cmp_s        CMP_I,
    input wire logic            SW_ON,
    input wire logic            SW_CLK,
    input wire logic [SS_W-1:0] SOFT_START_LEVEL,
    input wire logic            OUTPUT_OK_O,
    input wire logic            OUTPUT_OK_OE
);
    // ==========================================================
    // helper logic
    // slack of four cycles covers the synchroniser and output flop
    localparam int OK_MIN = (PG_DEGLITCH - 1) * OSC_DIVIDE - 4;
    logic [15:0] hi_run_q;  // cycles the ok-high comparator has held
    logic [15:0] hi_run_d;  // next value

    // saturating run length of the ok-high comparator
    always_comb begin
        hi_run_d = hi_run_q;
        if (!CMP_I.fb_ok_hi) begin
            hi_run_d = '0;
        end else if (hi_run_q != 16'hffff) begin
            hi_run_d = hi_run_q + 16'h1;
        end
    end

    // register the run length
    always_ff @(posedge REF_CLK or negedge RST_N) begin
        if (!RST_N) begin
            hi_run_q <= '0;
        end else begin
            hi_run_q <= hi_run_d;
        end
    end

    // ==========================================================
    // assertions, one clock domain
    default clocking cb @(posedge REF_CLK); endclocking
    default disable iff (!RST_N);

    chk_ack_single: assert property (WB_ACK_O |=> !WB_ACK_O)
        else $error("bus acknowledge held past one cycle");
    chk_on_at_start: assert property ($rose(SW_ON) |-> SW_CLK)
        else $error("switch turned on outside a period start");
    chk_clk_pulse: assert property (SW_CLK |=> !SW_CLK)
        else $error("switching clock pulse too long");
    chk_trip_off: assert property (CMP_I.peak_trip [*5] |-> !SW_ON)
        else $error("switch on during peak trip");
    chk_limit_off: assert property (CMP_I.cur_limit [*5] |-> !SW_ON)
        else $error("switch on during current limit");
    chk_guard_off: assert property (CMP_I.fb_ov_hi [*5] |-> !SW_ON)
        else $error("switch on during overvoltage");
    chk_off_state: assert property ((CMP_I.en_below_lo && !CMP_I.en_above_hi) [*5]
        |-> !SW_ON && OUTPUT_OK_OE && SOFT_START_LEVEL == '0)
        else $error("disabled sequencer not idle");
    chk_hot_off: assert property (CMP_I.temp_hot [*5] |-> !SW_ON && OUTPUT_OK_OE)
        else $error("switching while hot");
    chk_ramp_step: assert property (SOFT_START_LEVEL != $past(SOFT_START_LEVEL)
        |-> SOFT_START_LEVEL == $past(SOFT_START_LEVEL) + 1'b1 || SOFT_START_LEVEL == '0)
        else $error("soft start level jumped");
    chk_ok_deglitch: assert property ($fell(OUTPUT_OK_OE) |-> $past(hi_run_q, 4) >= OK_MIN)
        else $error("output ok released before deglitch");
    chk_od_low: assert property (OUTPUT_OK_OE |-> !OUTPUT_OK_O)
        else $error("open-drain flag drives high");
endmodule

bind bkc_seq bkc_seq_properties #(.OSC_DIVIDE(OSC_DIVIDE)) u_props (
    .REF_CLK(REF_CLK), .RST_N(RST_N), .WB_ACK_O(WB_ACK_O), .CMP_I(CMP_I), .SW_ON(SW_ON),
    .SW_CLK(SW_CLK), .SOFT_START_LEVEL(SOFT_START_LEVEL), .OUTPUT_OK_O(OUTPUT_OK_O),
    .OUTPUT_OK_OE(OUTPUT_OK_OE)
);

// ==== verif/bkc_ok_load.sv ====
// supervisor side of the open-drain output-ok line, with its pull-up
`timescale 1ns/1ns

module bkc_ok_load (
    input wire logic ok_o,   // level driven while enabled
    input wire logic ok_oe,  // high while the sequencer pulls
    output logic     level   // what the supervisor sees
);
    // ==========================================================
    // wire resolution: the pull-up wins whenever the pin is released
    assign level = ok_oe ? ok_o : 1'b1;
endmodule

// ==== verif/bkc_seq_test.sv ====
// self-checking bench for the buck control sequencer
`timescale 1ns/1ns

module bkc_seq_test
    import bkc_pkg::*;
;
    localparam int D   = 4;              // shortened oscillator period
    localparam int SSL = 16;             // shortened soft start
    localparam int BL  = BURST_PERIODS;  // skip burst length
    logic            REF_CLK = 1'b0;     // 125 MHz reference
    logic            RST_N   = 1'b0;     // active low reset
    logic            wb_req  = 1'b0;     // cyc and stb together
    logic            wb_we   = 1'b0;     // write strobe
    logic [7:0]      wb_adr  = '0;       // byte address
    logic [3:0]      wb_sel  = '0;       // byte lanes
    logic [31:0]     wb_dat  = '0;       // write data
    logic [31:0]     wb_rd;              // read data
    logic            wb_ack;             // acknowledge
    bkc_cmp_s        cmp;                // comparator levels
    logic            sw_on;              // gate request
    logic            sw_clk;             // period start pulse
    logic [SS_W-1:0] ramp;               // soft start level
    logic            ok_o;               // open-drain level
    logic            ok_oe;              // open-drain enable
    logic            ok_level;           // resolved flag wire
    int              fails   = 0;        // mismatches
    int              n_tests = 0;        // comparisons

    bkc_seq #(.OSC_DIVIDE(D), .SS_LEN(SSL), .BURST_LEN(BL)) dut (
        .REF_CLK(REF_CLK), .RST_N(RST_N), .WB_CYC_I(wb_req), .WB_STB_I(wb_req), .WB_WE_I(wb_we),
        .WB_ADR_I(wb_adr), .WB_SEL_I(wb_sel), .WB_DAT_I(wb_dat), .WB_DAT_O(wb_rd), .WB_ACK_O(wb_ack),
        .CMP_I(cmp), .SW_ON(sw_on), .SW_CLK(sw_clk), .SOFT_START_LEVEL(ramp), .OUTPUT_OK_O(ok_o),
        .OUTPUT_OK_OE(ok_oe)
    );
    bkc_ok_load load (.ok_o(ok_o), .ok_oe(ok_oe), .level(ok_level));

    // ==========================================================
    // tasks
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            $display("Error at %0t: got %h expected %h", $time, got, exp);
            fails++;
        end
    endtask

    task automatic cycles(input int n);
        repeat (n) @(posedge REF_CLK);
    endtask

    // one classic cycle; request held until the edge that sees ack
    // a missing ack is caught by the cycle guard, not by a local limit
    task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
        @(posedge REF_CLK);
        wb_req <= 1'b1;
        wb_we <= we;
        wb_adr <= a;
        wb_sel <= 4'hf;
        wb_dat <= d;
        do begin
            @(posedge REF_CLK);
        end while (wb_ack !== 1'b1);
        q = wb_rd;
        wb_req <= 1'b0;
        wb_we <= 1'b0;
    endtask

    // edges until the next switching period start
    task automatic period(output int n);
        n = 0;
        do begin
            @(posedge REF_CLK);
            n++;
        end while (sw_clk !== 1'b1);
    endtask

    task automatic results();
        $display("comparisons %0d mismatches %0d", n_tests, fails);
        if (fails == 0 && n_tests > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    // ==========================================================
    // clock and hang guard, the run needs about 1000 cycles
    initial forever #4 REF_CLK = ~REF_CLK;
    initial begin
        cycles(6000);
        fails++;
        results();
    end

    // ==========================================================
    // main sequence
    initial begin
        int g;
        int k;
        logic [31:0] q;
        bkc_cmp_s m_c;
        bkc_cmp_s m_r;
        cmp = '0;
        cmp.en_below_lo = 1'b1;
        cmp.vin_below_fall = 1'b1;
        cmp.temp_cool = 1'b1;
        cmp.fb_ov_lo = 1'b1;
        cmp.fb_ok_lo = 1'b1;
        cycles(16);
        RST_N <= 1'b1;
        wb(1'b0, ADDR_CTRL, '0, q);
        check(q, {30'h0, CTRL_RESET});
        wb(1'b0, ADDR_STATUS, '0, q);
        check(q & 32'hff, 32'h04);
        wb(1'b1, 8'h0c, 32'hffffffff, q);
        wb(1'b0, 8'h0c, '0, q);
        check(q, 32'h0);
        check({sw_on, ok_level, ramp}, '0);
        // start running, full band
        cmp.en_below_lo <= 1'b0;
        cmp.en_above_hi <= 1'b1;
        cmp.vin_below_fall <= 1'b0;
        cmp.vin_above_rise <= 1'b1;
        // foldback bands: period length and reported band
        for (int i = 0; i < 4; i++) begin
            cmp.fb_ge_top <= (i < 1);
            cmp.fb_gt_mid <= (i < 2);
            cmp.fb_gt_bot <= (i < 3);
            period(g);
            period(g);
            period(g);
            check(g, D << i);
            check(sw_on, 1'b1);
            wb(1'b0, ADDR_STATUS, '0, q);
            check((q >> 8) & 32'h3, i);
        end
        check(ramp, SSL - 1);
        cmp.fb_ge_top <= 1'b1;
        cmp.fb_gt_mid <= 1'b1;
        cmp.fb_gt_bot <= 1'b1;
        while (ramp !== '0) @(posedge REF_CLK);
        check(ramp, 0);
        while (ramp !== 1) @(posedge REF_CLK);
        cycles((SSL - 2) * D - 1);
        check(ramp, SSL - 2);
        cycles(1);
        check(ramp, SSL - 1);
        cycles(2 * D);
        wb(1'b0, ADDR_STATUS, '0, q);
        check((q >> 7) & 32'h1, 1);
        // pulse skipping: idle, then one dip gives one burst
        cmp.skip_in_reg <= 1'b1;
        cycles(8 * D);
        k = 0;
        repeat (8 * D) begin
            @(posedge REF_CLK);
            k += (sw_on === 1'b1);
        end
        check(k, 0);
        k = 0;
        for (int j = 0; j < 15 * D; j++) begin
            @(posedge REF_CLK);
            cmp.skip_in_reg <= (j >= D);
            k += (sw_clk === 1'b1 && sw_on === 1'b1);
        end
        check(k, BL);
        wb(1'b1, ADDR_CTRL, 32'h3, q);
        period(g);
        period(g);
        check(sw_on, 1'b1);
        // software enable bit off: switch off and ramp reset
        wb(1'b1, ADDR_CTRL, 32'h2, q);
        cycles(2);
        check({sw_on, ramp}, '0);
        wb(1'b1, ADDR_CTRL, 32'h3, q);
        // output-ok deglitch, including a short glitch
        m_c = '0;
        m_c.fb_ok_hi = 1'b1;
        m_c.fb_ok_lo = 1'b1;
        cmp <= cmp ^ m_c;
        cycles(28 * D);
        check(ok_level, 1'b0);
        cycles(6 * D);
        check(ok_level, 1'b1);
        cmp <= cmp ^ m_c;
        cycles(8 * D);
        cmp <= cmp ^ m_c;
        cycles(4 * D);
        check(ok_level, 1'b1);
        cmp <= cmp ^ m_c;
        cycles(34 * D);
        check(ok_level, 1'b0);
        cmp <= cmp ^ m_c;
        cycles(34 * D);
        // trip, current limit and overvoltage each cut the switch
        for (int i = 0; i < 3; i++) begin
            m_c = '0;
            case (i)
                0: m_c.peak_trip = 1'b1;
                1: m_c.cur_limit = 1'b1;
                default: begin
                    m_c.fb_ov_hi = 1'b1;
                    m_c.fb_ov_lo = 1'b1;
                end
            endcase
            cmp <= cmp ^ m_c;
            cycles(2 * D);
            check(sw_on, 1'b0);
            cmp <= cmp ^ m_c;
            period(g);
            period(g);
            check(sw_on, 1'b1);
        end
        // disable, lockout and thermal cutoff, with hysteresis
        for (int i = 0; i < 3; i++) begin
            m_c = '0;
            m_r = '0;
            case (i)
                0: begin
                    m_c.en_below_lo = 1'b1;
                    m_r.en_above_hi = 1'b1;
                end
                1: begin
                    m_c.vin_below_fall = 1'b1;
                    m_r.vin_above_rise = 1'b1;
                end
                default: begin
                    m_c.temp_hot = 1'b1;
                    m_r.temp_cool = 1'b1;
                end
            endcase
            cmp <= cmp ^ m_c ^ m_r;
            cycles(8);
            check({sw_on, ok_level, ramp}, '0);
            cmp <= cmp ^ m_c;
            cycles(8);
            check(sw_on, 1'b0);
            cmp <= cmp ^ m_r;
            cycles(16);
            check(sw_on, 1'b1);
            check(ramp inside {[1:4]}, 1'b1);
        end
        // mid-run reset returns the sequencer to its idle, locked-out state
        RST_N <= 1'b0;
        cycles(2);
        check({sw_on, sw_clk, ok_level, ramp}, '0);
        RST_N <= 1'b1;
        wb(1'b0, ADDR_CTRL, '0, q);
        check(q, {30'h0, CTRL_RESET});
        results();
    end
endmodule
